// ==== shared/usb_ep_pkg.sv ====
// constants, field layouts and types for the usb endpoint status and descriptor block
// ----------------------------------------------------------------------------
// Notes on behaviour
// RULE1: completed transfer status sits in a four-entry queue; oldest shown in window
// RULE2: each finished buffer pushes its status behind any entries still pending; code drops keep-mode completions and completions while full
// RULE3: clearing the complete flag pops the queue; flag returns within 5 cycles
// RULE4: empty queue after pop leaves the flag clear; window contents then meaningless
// RULE5: any endpoint request answered with NAK while all four entries are occupied
// RULE6: window bits 6..3 give the endpoint number of the last updated descriptor
// RULE7: window bit 2 is one for IN tokens, zero for OUT or SETUP
// RULE8: window bit 1 is one for the odd descriptor bank, zero for even
// RULE9: sixteen endpoint control registers, identical layout, one per endpoint
// RULE10: control bit 4 enables handshakes; clear means none, as for isochronous
// RULE11: with both directions on, bit 3 clear allows SETUP, set rejects it
// RULE12: control bit 2 enables OUT transactions, bit 1 enables IN transactions
// RULE13: control bit 0 set on every STALL issued; stays until firmware or reset clears
// RULE14: answer only the programmed address; it resets on bus reset or core reset
// RULE15: every SOF frame number captured into read-only low byte and high three bits
// RULE16: shared endpoint memory is dual-port, 1 Kbyte, at 400h through 7FFh
// RULE17: 400h to 4FFh holds the descriptor table; the rest holds data buffers
// RULE18: each of up to 64 descriptors: status, count, address low, address high
// RULE19: 32, 33 or 64 descriptor sets depending on buffering layout; code always uses the 64-set layout
// RULE20: descriptor table spans at least 8 bytes and at most 256 bytes
// RULE21: descriptor bytes are plain ram until enabled; contents unknown after reset
// RULE22: firmware should not touch memory the engine is using; use ownership bit
// RULE23: firmware should set up a descriptor before enabling its endpoint
// RULE24: status bit 7 is ownership; engine clears it on completion unless keep/stall
// ----------------------------------------------------------------------------
package usb_ep_pkg;
    // ------------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
    localparam int unsigned INSTR_CYCLE_NS = CLK_PERIOD_NS;  // one instruction cycle per core clock
    localparam int unsigned REARM_TCY      = 5;
    localparam int unsigned REARM_NS       = REARM_TCY * INSTR_CYCLE_NS;
    localparam int unsigned REARM_CYC      = REARM_NS / CLK_PERIOD_NS;  // longest time, rounded down

    // ------------------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------------
    localparam logic [11:0] OFS_STATUS_WIN = 12'h000;
    localparam logic [11:0] OFS_FLAG_CTRL  = 12'h004;
    localparam logic [11:0] OFS_BUS_ADDR   = 12'h008;
    localparam logic [11:0] OFS_FRAME_LOW  = 12'h00C;
    localparam logic [11:0] OFS_FRAME_HIGH = 12'h010;
    localparam logic [11:0] OFS_EPCTL_BASE = 12'h040;
    localparam logic [11:0] RAM_BASE       = 12'h400;
    localparam logic [11:0] RAM_LAST       = 12'h7FF;
    localparam logic [11:0] BDT_LAST       = 12'h4FF;

    // ------------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------------
    localparam int unsigned QUEUE_DEPTH   = 4;
    localparam int unsigned NUM_EP        = 16;
    localparam int unsigned NUM_BD        = 64;
    localparam int unsigned RAM_BYTES     = 1024;
    localparam int unsigned BDT_MIN_BYTES = 8;
    localparam int unsigned BDT_MAX_BYTES = 256;

    // ------------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------------
    localparam int unsigned WIN_EP_LSB   = 3;
    localparam int unsigned WIN_DIR_BIT  = 2;
    localparam int unsigned WIN_ODD_BIT  = 1;
    localparam int unsigned EP_HSHK_BIT  = 4;
    localparam int unsigned EP_CONDIS_BIT = 3;
    localparam int unsigned EP_OUTEN_BIT = 2;
    localparam int unsigned EP_INEN_BIT  = 1;
    localparam int unsigned EP_STALL_BIT = 0;
    localparam int unsigned FLAG_BIT     = 0;
    localparam int unsigned FULL_BIT     = 1;
    localparam int unsigned DS_OWN_BIT   = 7;

    // ------------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------------
    localparam logic [4:0]  EPCTL_RST    = 5'h00;
    localparam logic [6:0]  BUS_ADDR_RST = 7'h00;
    localparam logic [10:0] FRAME_RST    = 11'h000;

    // ------------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {PID_OUT, PID_IN, PID_SETUP} token_pid_t;
    typedef enum logic [1:0] {RESP_NONE, RESP_ACCEPT, RESP_NAK} resp_code_t;
endpackage : usb_ep_pkg

// ==== rtl/usb_endpoint_status_bdt.sv ====
// status queue, endpoint control, address, frame number and shared endpoint ram
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module usb_endpoint_status_bdt (
    input  wire logic                   core_clk_i,        // core clock, 10 MHz
    input  wire logic                   rst_i,             // synchronous reset, high
    input  wire logic [11:0]            avs_address_i,     // byte address
    input  wire logic                   avs_read_i,        // read request
    input  wire logic                   avs_write_i,       // write request
    input  wire logic [31:0]            avs_writedata_i,   // write data
    input  wire logic [3:0]             avs_byteenable_i,  // byte lanes
    output logic      [31:0]            avs_readdata_o,    // read data
    output logic                        avs_waitrequest_o, // stall the master
    input  wire logic                   bus_reset_i,       // usb bus reset seen, pulse
    input  wire logic                   sof_i,             // sof token received, pulse
    input  wire logic [10:0]            sof_frame_i,       // frame number of that sof
    input  wire logic                   tok_valid_i,       // token arrived, pulse
    input  wire logic [6:0]             tok_addr_i,        // token device address
    input  wire logic [3:0]             tok_ep_i,          // token endpoint
    input  wire usb_ep_pkg::token_pid_t tok_pid_i,         // token kind
    output logic                        resp_valid_o,      // decision valid, pulse
    output usb_ep_pkg::resp_code_t      resp_code_o,       // accept or nak
    output logic                        resp_handshake_o,  // send a handshake packet
    input  wire logic                   stall_i,           // engine issued a stall, pulse
    input  wire logic [3:0]             stall_ep_i,        // endpoint of that stall
    input  wire logic                   xfer_done_i,       // engine done with a buffer, pulse
    input  wire logic [3:0]             xfer_ep_i,         // its endpoint
    input  wire logic                   xfer_dir_i,        // 1 = in token
    input  wire logic                   xfer_odd_i,        // 1 = odd bank
    input  wire logic                   xfer_keep_i,       // keep or buffer-stall mode
    input  wire logic [6:0]             xfer_stat_i,       // new descriptor status bits 6..0
    input  wire logic                   eng_req_i,         // engine ram access
    input  wire logic                   eng_we_i,          // engine ram write
    input  wire logic [9:0]             eng_addr_i,        // engine ram byte address
    input  wire logic [7:0]             eng_wdata_i,       // engine ram write data
    output logic      [7:0]             eng_rdata_o,       // engine ram read data
    output logic                        eng_gnt_o,         // engine access done, pulse
    output logic                        xfer_flag_o,       // transfer complete flag
    output logic                        queue_full_o       // status queue full
);
    localparam int REARM_BOUND = int'(usb_ep_pkg::REARM_CYC);

    // ------------------------------------------------------------------------
    // bus slave handshake
    // ------------------------------------------------------------------------
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        req;
    logic        acc_wr;
    logic [11:0] word_addr;

    assign req       = avs_read_i | avs_write_i;
    assign acc_wr    = avs_write_i & ~wait_q;  // writes act at the edge the master sees the answer
    assign word_addr = {avs_address_i[11:2], 2'b00};

    // one wait cycle, then a single low cycle that carries the answer
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req & wait_q);
        end
    end

    // read data is latched during the wait cycle and stands through the low cycle
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && wait_q) begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------------
    logic       wr_flag;
    logic       wr_addr;
    logic       wr_ep;
    logic       in_ram;
    logic       ram_wr;
    logic [3:0] ep_sel;

    assign in_ram  = (word_addr >= usb_ep_pkg::RAM_BASE) && (word_addr <= usb_ep_pkg::RAM_LAST); // RULE16
    assign ram_wr  = acc_wr & in_ram;
    assign wr_flag = acc_wr & avs_byteenable_i[0] & (word_addr == usb_ep_pkg::OFS_FLAG_CTRL);
    assign wr_addr = acc_wr & avs_byteenable_i[0] & (word_addr == usb_ep_pkg::OFS_BUS_ADDR);
    assign wr_ep   = acc_wr & avs_byteenable_i[0] & (word_addr[11:6] == usb_ep_pkg::OFS_EPCTL_BASE[11:6]);
    assign ep_sel  = word_addr[5:2];

    // ------------------------------------------------------------------------
    // transfer status queue
    // ------------------------------------------------------------------------
    logic [5:0] entry_q [usb_ep_pkg::QUEUE_DEPTH];  // {endpoint, dir, odd}
    logic [1:0] head_q;
    logic [2:0] count_q;
    logic       flag_q;
    logic       full;
    logic       push;
    logic       pop;
    logic [1:0] tail;
    logic [7:0] window;

    assign full   = (count_q == 3'(usb_ep_pkg::QUEUE_DEPTH));
    assign push   = xfer_done_i & ~xfer_keep_i & ~full;                      // RULE2
    assign pop    = wr_flag & avs_writedata_i[usb_ep_pkg::FLAG_BIT] & flag_q; // RULE3
    assign tail   = head_q + count_q[1:0];
    // oldest entry; bits 7 and 0 read as zero
    assign window = {1'b0, entry_q[head_q], 1'b0}; // RULE6 RULE7 RULE8

    // entries are written at the tail; keep-mode completions never reach the queue
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < int'(usb_ep_pkg::QUEUE_DEPTH); i++) begin
                entry_q[i] <= 6'h00;
            end
        end else if (push) begin
            entry_q[tail] <= {xfer_ep_i, xfer_dir_i, xfer_odd_i}; // RULE1
        end
    end

    // occupancy: a push in the clearing cycle is kept, but a completion while full is dropped even in the clearing cycle
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            head_q  <= 2'h0;
            count_q <= 3'h0;
        end else begin
            head_q  <= head_q + {1'b0, pop};
            count_q <= count_q + {2'b00, push} - {2'b00, pop};
        end
    end

    // flag falls on a clear and rises again the cycle after if entries remain
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (pop) begin
            flag_q <= 1'b0;
        end else if (!flag_q && count_q != 3'h0) begin
            flag_q <= 1'b1; // RULE3 RULE4
        end
    end

    // ------------------------------------------------------------------------
    // endpoint control registers
    // ------------------------------------------------------------------------
    logic [4:0]  epctl_q [usb_ep_pkg::NUM_EP];
    logic [15:0] stall_vec;

    for (genvar g = 0; g < int'(usb_ep_pkg::NUM_EP); g++) begin : g_ep
        // the stall set is written last so it wins over a firmware clear
        always_ff @(posedge core_clk_i) begin
            if (rst_i) begin
                epctl_q[g] <= usb_ep_pkg::EPCTL_RST; // RULE9
            end else begin
                if (wr_ep && ep_sel == 4'(g)) begin
                    epctl_q[g] <= avs_writedata_i[4:0]; // RULE12
                end
                if (stall_i && stall_ep_i == 4'(g)) begin
                    epctl_q[g][usb_ep_pkg::EP_STALL_BIT] <= 1'b1; // RULE13
                end
            end
        end
        assign stall_vec[g] = epctl_q[g][usb_ep_pkg::EP_STALL_BIT];
    end

    // ------------------------------------------------------------------------
    // device address and frame number
    // ------------------------------------------------------------------------
    logic [6:0]  bus_addr_q;
    logic [10:0] frame_q;

    // a bus reset drops the address even while firmware is writing it
    always_ff @(posedge core_clk_i) begin
        if (rst_i || bus_reset_i) begin
            bus_addr_q <= usb_ep_pkg::BUS_ADDR_RST; // RULE14
        end else if (wr_addr) begin
            bus_addr_q <= avs_writedata_i[6:0];
        end
    end

    // frame number follows every sof
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            frame_q <= usb_ep_pkg::FRAME_RST;
        end else if (sof_i) begin
            frame_q <= sof_frame_i; // RULE15
        end
    end

    // ------------------------------------------------------------------------
    // token decision
    // ------------------------------------------------------------------------
    logic [4:0] tok_ctl;
    logic       tok_match;
    logic       tok_allowed;

    assign tok_ctl   = epctl_q[tok_ep_i];
    assign tok_match = (tok_addr_i == bus_addr_q); // RULE14

    // setup needs both directions on and control transfers not disabled
    always_comb begin
        case (tok_pid_i)
            usb_ep_pkg::PID_OUT:   tok_allowed = tok_ctl[usb_ep_pkg::EP_OUTEN_BIT]; // RULE12
            usb_ep_pkg::PID_IN:    tok_allowed = tok_ctl[usb_ep_pkg::EP_INEN_BIT];
            usb_ep_pkg::PID_SETUP: tok_allowed = tok_ctl[usb_ep_pkg::EP_OUTEN_BIT]
                                               & tok_ctl[usb_ep_pkg::EP_INEN_BIT]
                                               & ~tok_ctl[usb_ep_pkg::EP_CONDIS_BIT]; // RULE11
            default:               tok_allowed = 1'b0;
        endcase
    end

    // registered answer, one cycle after the token
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            resp_valid_o     <= 1'b0;
            resp_code_o      <= usb_ep_pkg::RESP_NONE;
            resp_handshake_o <= 1'b0;
        end else begin
            resp_valid_o     <= tok_valid_i & tok_match & tok_allowed;
            resp_code_o      <= !(tok_valid_i && tok_match && tok_allowed) ? usb_ep_pkg::RESP_NONE
                              : full ? usb_ep_pkg::RESP_NAK : usb_ep_pkg::RESP_ACCEPT; // RULE5
            resp_handshake_o <= tok_valid_i & tok_match & tok_allowed
                              & tok_ctl[usb_ep_pkg::EP_HSHK_BIT]; // RULE10
        end
    end

    // ------------------------------------------------------------------------
    // shared endpoint ram
    // ------------------------------------------------------------------------
    logic [7:0] ram_q [usb_ep_pkg::RAM_BYTES];
    logic [9:0] cpu_byte;
    logic [9:0] bd_stat_addr;
    logic       own_wr;
    logic       eng_go;

    assign cpu_byte     = {avs_address_i[9:2], 2'b00};
    // all-banks layout: 64 descriptor sets of four bytes fill the 256-byte table
    // top two bits held at zero so write-back never leaves the 256-byte table
    assign bd_stat_addr = {2'b00, xfer_ep_i, xfer_dir_i, xfer_odd_i, 2'b00}; // RULE18 RULE19 RULE17 RULE20
    assign own_wr       = xfer_done_i & ~xfer_keep_i;
    // completion write-back takes the engine port; the engine retries next cycle
    assign eng_go       = eng_req_i & ~own_wr;

    // no reset: descriptor bytes are ordinary ram with unknown content (RULE21 below)
    always_ff @(posedge core_clk_i) begin
        for (int k = 0; k < 4; k++) begin
            if (ram_wr && avs_byteenable_i[k]) begin
                ram_q[cpu_byte + 10'(k)] <= avs_writedata_i[8*k +: 8]; // RULE16 RULE21
            end
        end
        if (own_wr) begin
            ram_q[bd_stat_addr] <= {1'b0, xfer_stat_i}; // RULE24
        end else if (eng_go && eng_we_i) begin
            ram_q[eng_addr_i] <= eng_wdata_i;
        end
    end

    // engine side read data and grant
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            eng_rdata_o <= 8'h00;
            eng_gnt_o   <= 1'b0;
        end else begin
            eng_gnt_o <= eng_go;
            if (eng_go) begin
                eng_rdata_o <= ram_q[eng_addr_i];
            end
        end
    end

    // ------------------------------------------------------------------------
    // read mux and status outputs
    // ------------------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;  // unmapped words read zero
        if (in_ram) begin
            rdata_d = {ram_q[cpu_byte + 10'h003], ram_q[cpu_byte + 10'h002],
                       ram_q[cpu_byte + 10'h001], ram_q[cpu_byte]};
        end else if (word_addr[11:6] == usb_ep_pkg::OFS_EPCTL_BASE[11:6]) begin
            rdata_d = {27'h0, epctl_q[ep_sel]};
        end else begin
            case (word_addr)
                usb_ep_pkg::OFS_STATUS_WIN: rdata_d = {24'h0, window};
                usb_ep_pkg::OFS_FLAG_CTRL:  rdata_d = {30'h0, full, flag_q};
                usb_ep_pkg::OFS_BUS_ADDR:   rdata_d = {25'h0, bus_addr_q};
                usb_ep_pkg::OFS_FRAME_LOW:  rdata_d = {24'h0, frame_q[7:0]};
                usb_ep_pkg::OFS_FRAME_HIGH: rdata_d = {29'h0, frame_q[10:8]};
                default:                    rdata_d = 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;

    // mirror flags so the outputs come straight from flops
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            xfer_flag_o  <= 1'b0;
            queue_full_o <= 1'b0;
        end else begin
            xfer_flag_o  <= (flag_q & ~pop) | (~flag_q & ~pop & (count_q != 3'h0));
            queue_full_o <= (count_q + {2'b00, push} - {2'b00, pop}) == 3'(usb_ep_pkg::QUEUE_DEPTH);
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    chk_queue_depth: assert property (count_q <= 3'(usb_ep_pkg::QUEUE_DEPTH)) // RULE1
        else $error("status queue over depth");
    chk_flag_rearm: assert property ((pop && count_q > 3'h1) |-> ##[1:REARM_BOUND] flag_q) // RULE3
        else $error("flag not raised again after clear");
    chk_flag_stays: assert property ((pop && count_q == 3'h1 && !push) |=> !flag_q [*2]) // RULE4
        else $error("flag raised with empty queue");
    chk_full_nak: assert property ((tok_valid_i && tok_match && tok_allowed && full)
        |=> resp_valid_o && resp_code_o == usb_ep_pkg::RESP_NAK) // RULE5
        else $error("full queue did not nak");
    chk_window_ep: assert property ((push && count_q == 3'h0)
        |=> window[6:3] == $past(xfer_ep_i)) // RULE6
        else $error("window endpoint wrong");
    chk_window_dir: assert property ((push && count_q == 3'h0)
        |=> window[2] == $past(xfer_dir_i) && window[0] == 1'b0) // RULE7
        else $error("window direction wrong");
    chk_window_odd: assert property ((push && count_q == 3'h0)
        |=> window[1] == $past(xfer_odd_i) && window[7] == 1'b0) // RULE8
        else $error("window bank wrong");
    chk_setup_gate: assert property ((tok_valid_i && tok_match && tok_pid_i == usb_ep_pkg::PID_SETUP
        && tok_ctl[usb_ep_pkg::EP_CONDIS_BIT]) |=> !resp_valid_o) // RULE11
        else $error("setup accepted on disabled endpoint");
    chk_stall_sticky: assert property (stall_i |=> stall_vec[$past(stall_ep_i)]) // RULE13
        else $error("stall bit not set");
    chk_addr_reset: assert property (bus_reset_i |=> bus_addr_q == 7'h00) // RULE14
        else $error("address survived bus reset");
    chk_addr_filter: assert property ((tok_valid_i && !tok_match) |=> !resp_valid_o) // RULE14
        else $error("answered foreign address");
    chk_frame_take: assert property (sof_i |=> frame_q == $past(sof_frame_i)) // RULE15
        else $error("frame number not captured");
    chk_own_clear: assert property (own_wr |=> !ram_q[$past(bd_stat_addr)][usb_ep_pkg::DS_OWN_BIT]) // RULE24
        else $error("ownership bit left set");

    cov_queue_full: cover property (push ##1 full);
    cov_rearm:      cover property (pop ##[1:REARM_BOUND] flag_q);
    cov_nak:        cover property (resp_valid_o && resp_code_o == usb_ep_pkg::RESP_NAK);
endmodule : usb_endpoint_status_bdt

// ==== tb/usb_host_model.sv ====
// host side model: issues tokens toward the device
`timescale 1ns/1ps
module usb_host_model (
    input  wire logic              clk_i,       // core clock
    output logic                   tok_valid_o, // token pulse
    output logic [6:0]             tok_addr_o,  // token device address
    output logic [3:0]             tok_ep_o,    // token endpoint
    output usb_ep_pkg::token_pid_t tok_pid_o    // token kind
);
    initial begin
        tok_valid_o = 1'b0;
        tok_addr_o  = 7'h00;
        tok_ep_o    = 4'h0;
        tok_pid_o   = usb_ep_pkg::PID_OUT;
    end
    // one-cycle token; address and endpoint scrambled after so stale values never look valid
    task automatic tok(input logic [6:0] a, input logic [3:0] e, input usb_ep_pkg::token_pid_t p);
        tok_addr_o  <= a;
        tok_ep_o    <= e;
        tok_pid_o   <= p;
        tok_valid_o <= 1'b1;
        @(posedge clk_i);
        tok_valid_o <= 1'b0;
        tok_addr_o  <= ~a;
        tok_ep_o    <= ~e;
    endtask : tok
endmodule : usb_host_model

// ==== tb/usb_endpoint_status_bdt_bench.sv ====
// self-checking bench for the endpoint status and descriptor block
`timescale 1ns/1ps
module usb_endpoint_status_bdt_bench;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, brst = 1'b0, sof = 1'b0, stl = 1'b0, dn = 1'b0;
    logic dir = 1'b0, odd = 1'b0, keep = 1'b0, tv, rv, hs, wreq, flag, full;
    logic [11:0] adr = 12'h000;
    logic [31:0] wd = 32'h0, q, rdata;
    logic [3:0] sep = 4'h0, xep = 4'h0, te;
    logic [10:0] frm = 11'h000;
    logic [6:0] stat = 7'h00, ta;
    logic er = 1'b0, ew = 1'b0, eg;
    logic [9:0] ea = 10'h000;
    logic [7:0] ewd = 8'h00, erd;
    usb_ep_pkg::token_pid_t tp;
    usb_ep_pkg::resp_code_t rc;
    int fail_count = 0, n_tests = 0;
    usb_host_model u_usb_host_model (.clk_i(clk), .tok_valid_o(tv), .tok_addr_o(ta), .tok_ep_o(te), .tok_pid_o(tp));
    usb_endpoint_status_bdt u_usb_endpoint_status_bdt (.core_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .bus_reset_i(brst), .sof_i(sof), .sof_frame_i(frm), .tok_valid_i(tv),
        .tok_addr_i(ta), .tok_ep_i(te), .tok_pid_i(tp), .resp_valid_o(rv), .resp_code_o(rc), .resp_handshake_o(hs),
        .stall_i(stl), .stall_ep_i(sep), .xfer_done_i(dn), .xfer_ep_i(xep), .xfer_dir_i(dir), .xfer_odd_i(odd),
        .xfer_keep_i(keep), .xfer_stat_i(stat), .eng_req_i(er), .eng_we_i(ew), .eng_addr_i(ea),
        .eng_wdata_i(ewd), .eng_rdata_o(erd), .eng_gnt_o(eg), .xfer_flag_o(flag), .queue_full_o(full));
    initial forever #50 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // avalon access: hold until waitrequest seen low at an edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);  // let the previous release stand for an edge
        adr <= a; wd <= d; wr <= w; rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        wr <= 1'b0; rd <= 1'b0;
    endtask : bus
    task automatic tok_chk(input logic [3:0] e, input usb_ep_pkg::token_pid_t p, input logic [3:0] x);
        u_usb_host_model.tok(7'h11, e, p);
        @(posedge clk);
        chk(x[3] ? {rv, rc, hs} : rv, x);
    endtask : tok_chk
    task automatic test_queue();
        bus(1, 12'h410, 32'h80);
        bus(1, 12'h008, 32'h11);
        bus(1, 12'h048, 32'h16);
        dn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            xep <= 4'(i + 1); dir <= i[0]; odd <= i[1]; stat <= 7'h40 | 7'(i);
            @(posedge clk);
        end
        dn <= 1'b0;
        repeat (3) @(posedge clk);
        chk(full, 1);
        tok_chk(2, usb_ep_pkg::PID_IN, 4'hD);
        for (int i = 0; i < 4; i++) begin
            bus(0, 12'h000, 0);
            chk(q, {4'(i + 1), i[0], i[1], 1'b0});
            bus(0, 12'h400 | {4'(i + 1), i[0], i[1], 2'b00}, 0);
            chk(q[7:0], 8'h40 | 8'(i));
            bus(1, 12'h004, 32'h1);
            repeat (5) @(posedge clk);
            chk(flag, i < 3);
        end
        $display("queue test done");
    endtask : test_queue
    task automatic test_ctrl();
        bus(1, 12'h054, 32'h0E);
        tok_chk(5, usb_ep_pkg::PID_SETUP, 0);
        tok_chk(5, usb_ep_pkg::PID_IN, 4'hA);
        sep <= 5; stl <= 1'b1;
        @(posedge clk);
        stl <= 1'b0;
        bus(0, 12'h054, 0);
        chk(q, 32'h0F);
        bus(1, 12'h054, 32'h16);
        tok_chk(5, usb_ep_pkg::PID_SETUP, 4'hB);
        bus(1, 12'h054, 32'h12);
        tok_chk(5, usb_ep_pkg::PID_OUT, 0);
        bus(0, 12'h048, 0);
        chk(q, 32'h16);
        $display("control test done");
    endtask : test_ctrl
    task automatic test_addr();
        frm <= 11'h5A3; sof <= 1'b1;
        @(posedge clk);
        sof <= 1'b0;
        bus(0, 12'h00C, 0);
        chk(q, 32'hA3);
        bus(0, 12'h010, 0);
        chk(q, 32'h5);
        brst <= 1'b1;
        @(posedge clk);
        brst <= 1'b0;
        bus(0, 12'h008, 0);
        chk(q, 0);
        tok_chk(2, usb_ep_pkg::PID_IN, 0);
        bus(0, 12'h020, 0);
        chk(q, 0);
        $display("address test done");
    endtask : test_addr
    task automatic test_ram();
        bus(1, 12'h500, 32'h44332211);
        ea <= 10'h103; ewd <= 8'h5C; ew <= 1'b1; er <= 1'b1;
        @(posedge clk);
        ea <= 10'h102; ew <= 1'b0;
        @(posedge clk);
        er <= 1'b0;
        @(posedge clk);
        chk({eg, erd}, 9'h133);
        bus(0, 12'h500, 0);
        chk(q, 32'h5C332211);
        $display("ram test done");
    endtask : test_ram
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    // watchdog: far beyond the roughly 130 cycles the tests need
    initial begin
        #400000;
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        test_queue();
        test_ctrl();
        test_addr();
        test_ram();
        finish_test();
    end
endmodule : usb_endpoint_status_bdt_bench
